// >>> design/spicc_pkg.sv
// constants and types shared by the serial control block
package spicc_pkg;

	// ************************************************************
	// register offsets and reset values
	// ************************************************************
	localparam logic [2:0] OFS_CONTROL_PRIMARY   = 3'h0;
	localparam logic [2:0] OFS_CONTROL_SECONDARY = 3'h1;
	localparam logic [2:0] OFS_STATUS            = 3'h3;
	localparam logic [2:0] OFS_DATA              = 3'h5;
	localparam logic [7:0] RST_CONTROL_PRIMARY   = 8'h04;
	localparam logic [7:0] RST_CONTROL_SECONDARY = 8'h00;
	localparam logic [7:0] MASK_CONTROL_SECONDARY = 8'h1B; // bits 7,6,5,2 read zero

	// ************************************************************
	// field positions, primary control
	// ************************************************************
	localparam int BIT_RX_FAULT_IRQ_ENABLE = 7;
	localparam int BIT_SYSTEM_ENABLE       = 6;
	localparam int BIT_TX_EMPTY_IRQ_ENABLE = 5;
	localparam int BIT_MASTER_SELECT       = 4;
	localparam int BIT_CLOCK_POLARITY      = 3;
	localparam int BIT_CLOCK_PHASE         = 2;
	localparam int BIT_SELECT_OUTPUT_ENABLE = 1;
	localparam int BIT_LOW_BIT_FIRST       = 0;

	// ************************************************************
	// field positions, secondary control and status
	// ************************************************************
	localparam int BIT_MODE_FAULT_ENABLE   = 4;
	localparam int BIT_SINGLE_WIRE_OE      = 3;
	localparam int BIT_WAIT_CLOCK_STOP     = 1;
	localparam int BIT_SINGLE_WIRE_SELECT  = 0;
	localparam int BIT_RECEIVE_FULL        = 7;
	localparam int BIT_TRANSMIT_EMPTY      = 5;
	localparam int BIT_MODE_FAULT          = 4;

	// ************************************************************
	// counts
	// ************************************************************
	localparam int          HALF_BIT_CYCLES  = 4;  // bus clocks per serial clock half period
	localparam logic [4:0]  EDGES_PER_BYTE   = 5'h10; // 8 bits, two edges each

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_END   = 3'b100
	} spicc_state_e;

endpackage

// >>> design/spicc_ctrl.sv
// serial interface control, configuration, pin steering and byte engine
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// Operation
// - receive-full or mode-fault interrupt gated by bit 7
// - disabling aborts transfer, empties buffers, resets machines
// - disabled: receive flag cleared, transmit empty set
// - bit 5 gates transmit-empty interrupt
// - bit 4 chooses slave or master role
// - bit 3 inverts serial clock idle level
// - bit 2 places first edge mid or start
// - bit 0 chooses msb or lsb first
// - slave: select pin always active-low input
// - master without fault enable releases select pin
// - master fault enable only: select detects fault
// - master fault enable and output: drives select
// - secondary bit 0 selects single-wire data
// - single-wire: slave uses miso, master mosi
// - secondary bit 3 drives shared data pin
// - secondary bit 1 stops clocks in wait
// - secondary bits 7,6,5,2 read zero
// - disabled: all four pins released
module spicc_ctrl #(
	parameter int HALF_CYCLES = spicc_pkg::HALF_BIT_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       wait_mode,
	output logic            irq,
	input  wire logic       sclk_in,
	output logic            sclk_out,
	output logic            sclk_oe,
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe,
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe,
	input  wire logic       ss_n_in,
	output logic            ss_n_out,
	output logic            ss_n_oe
);

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (HALF_CYCLES < 2 || HALF_CYCLES > 255) begin : g_bad_half
		$error("HALF_CYCLES must lie in 2..255");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0]              ctrl1;
		logic [7:0]              ctrl2;
		logic [7:0]              tx_buf;
		logic                    tx_full;
		logic [7:0]              rx_buf;
		logic                    rf;
		logic                    mf;
		logic                    mf_arm;
		logic [7:0]              tx_sh;
		logic [7:0]              rx_sh;
		spicc_pkg::spicc_state_e state;
		logic [4:0]              edge_cnt;
		logic [7:0]              div_cnt;
		logic                    sck;
		logic                    sclk_m, sclk_s, sclk_p;
		logic                    mosi_m, mosi_s;
		logic                    miso_m, miso_s;
		logic                    ss_m, ss_s;
		logic [7:0]              rdata;
		logic                    irq;
		logic                    sclk_o, sclk_e, mosi_o, mosi_e, miso_o, miso_e, ss_o, ss_e;
	} spicc_reg_s;

	spicc_reg_s q, n;

	localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

	// next bit to launch, by shift order
	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		return lsb ? sh[0] : sh[7];
	endfunction

	// shift one bit in, by shift order
	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic din, input logic lsb);
		return lsb ? {din, sh[7:1]} : {sh[6:0], din};
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	logic en, mst, clock_phase, lsb, run, ev, din;
	logic [4:0] k;

	always_comb begin
		n       = q;
		n.rdata = 8'h00;
		k       = q.edge_cnt + 5'h01;
		en      = q.ctrl1[spicc_pkg::BIT_SYSTEM_ENABLE];
		mst     = q.ctrl1[spicc_pkg::BIT_MASTER_SELECT];
		clock_phase    = q.ctrl1[spicc_pkg::BIT_CLOCK_PHASE];
		lsb     = q.ctrl1[spicc_pkg::BIT_LOW_BIT_FIRST];
		run     = en && !(wait_mode && q.ctrl2[spicc_pkg::BIT_WAIT_CLOCK_STOP]);

		// two-flop synchronisers for every pin
		n.sclk_m = sclk_in;
		n.sclk_s = q.sclk_m;
		n.sclk_p = q.sclk_s;
		n.mosi_m = mosi_in;
		n.mosi_s = q.mosi_m;
		n.miso_m = miso_in;
		n.miso_s = q.miso_m;
		n.ss_m   = ss_n_in;
		n.ss_s   = q.ss_m;

		// data input pin depends on role and wire mode
		if (q.ctrl2[spicc_pkg::BIT_SINGLE_WIRE_SELECT])
			din = mst ? q.mosi_s : q.miso_s;
		else
			din = mst ? q.miso_s : q.mosi_s;

		// register writes
		if (wr) begin
			case (addr)
				spicc_pkg::OFS_CONTROL_PRIMARY: begin
					n.ctrl1 = wdata;
					if (q.mf_arm) begin
						n.mf     = 1'b0;
						n.mf_arm = 1'b0;
					end
				end
				spicc_pkg::OFS_CONTROL_SECONDARY: n.ctrl2 = wdata & spicc_pkg::MASK_CONTROL_SECONDARY;
				spicc_pkg::OFS_DATA: begin
					if (!q.tx_full && en) begin
						n.tx_buf  = wdata;
						n.tx_full = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// register reads, data the cycle after
		if (rd) begin
			case (addr)
				spicc_pkg::OFS_CONTROL_PRIMARY:   n.rdata = q.ctrl1;
				spicc_pkg::OFS_CONTROL_SECONDARY: n.rdata = q.ctrl2;
				spicc_pkg::OFS_STATUS: begin
					n.rdata[spicc_pkg::BIT_RECEIVE_FULL]   = q.rf;
					n.rdata[spicc_pkg::BIT_TRANSMIT_EMPTY] = !q.tx_full;
					n.rdata[spicc_pkg::BIT_MODE_FAULT]     = q.mf;
					n.mf_arm = q.mf;
				end
				spicc_pkg::OFS_DATA: begin
					n.rdata = q.rx_buf;
					n.rf    = 1'b0;
				end
				default: ;
			endcase
		end

		// edge event: divider tick for master, synced clock edge for slave
		ev = 1'b0;
		if (run && q.state == spicc_pkg::ST_SHIFT) begin
			if (mst) begin
				ev = (q.div_cnt == HALF_LAST);
				n.div_cnt = ev ? 8'h00 : q.div_cnt + 8'h01;
			end else begin
				ev = (q.sclk_s != q.sclk_p);
			end
		end

		// byte engine
		case (q.state)
			spicc_pkg::ST_IDLE: begin
				n.edge_cnt = 5'h00;
				n.div_cnt  = 8'h00;
				n.sck      = 1'b0;
				if (run && mst && q.tx_full) begin
					n.tx_sh   = q.tx_buf;
					n.tx_full = 1'b0;
					n.state   = spicc_pkg::ST_SHIFT;
				end else if (run && !mst && !q.ss_s) begin
					n.tx_sh   = q.tx_full ? q.tx_buf : 8'h00;
					if (q.tx_full)
						n.tx_full = 1'b0; // a write landing now stays queued
					n.state   = spicc_pkg::ST_SHIFT;
				end
			end
			spicc_pkg::ST_SHIFT: begin
				if (!mst && q.ss_s) begin
					n.state = spicc_pkg::ST_IDLE; // deselected mid-byte: drop it
				end else if (ev) begin
					n.edge_cnt = k;
					if (mst)
						n.sck = !q.sck;
					if (k[0] ^ clock_phase)
						n.rx_sh = shift_in(q.rx_sh, din, lsb);
					else if (k != 5'h01)
						n.tx_sh = lsb ? {1'b0, q.tx_sh[7:1]} : {q.tx_sh[6:0], 1'b0};
					if (k == spicc_pkg::EDGES_PER_BYTE)
						n.state = spicc_pkg::ST_END;
				end
			end
			spicc_pkg::ST_END: begin
				n.rx_buf = q.rx_sh;
				n.rf     = 1'b1; // set wins over a data read
				n.state  = spicc_pkg::ST_IDLE;
			end
			default: n.state = spicc_pkg::ST_IDLE;
		endcase

		// mode fault: select pulled low while this end masters
		if (en && mst && q.ctrl2[spicc_pkg::BIT_MODE_FAULT_ENABLE]
				&& !q.ctrl1[spicc_pkg::BIT_SELECT_OUTPUT_ENABLE] && !q.ss_s) begin
			n.mf = 1'b1;
			n.mf_arm = 1'b0;
			n.ctrl1[spicc_pkg::BIT_MASTER_SELECT] = 1'b0;
			n.state = spicc_pkg::ST_IDLE;
			n.sck = 1'b0;
		end

		// disabled: abort, empty buffers, initial state
		if (!n.ctrl1[spicc_pkg::BIT_SYSTEM_ENABLE]) begin
			n.state    = spicc_pkg::ST_IDLE;
			n.edge_cnt = 5'h00;
			n.div_cnt  = 8'h00;
			n.sck      = 1'b0;
			n.tx_full  = 1'b0;
			n.rf       = 1'b0;
		end

		// interrupt request
		n.irq = (n.ctrl1[spicc_pkg::BIT_RX_FAULT_IRQ_ENABLE] && (n.rf || n.mf))
			|| (n.ctrl1[spicc_pkg::BIT_TX_EMPTY_IRQ_ENABLE] && !n.tx_full);

		// pin steering, all released by default
		n.sclk_o = 1'b0;
		n.sclk_e = 1'b0;
		n.mosi_o = 1'b0;
		n.mosi_e = 1'b0;
		n.miso_o = 1'b0;
		n.miso_e = 1'b0;
		n.ss_o   = 1'b1;
		n.ss_e   = 1'b0;
		if (n.ctrl1[spicc_pkg::BIT_SYSTEM_ENABLE]) begin
			if (n.ctrl1[spicc_pkg::BIT_MASTER_SELECT]) begin
				n.sclk_e = 1'b1;
				n.sclk_o = n.sck ^ n.ctrl1[spicc_pkg::BIT_CLOCK_POLARITY];
				n.mosi_o = out_bit(n.tx_sh, n.ctrl1[spicc_pkg::BIT_LOW_BIT_FIRST]);
				n.mosi_e = n.ctrl2[spicc_pkg::BIT_SINGLE_WIRE_SELECT] ?
					n.ctrl2[spicc_pkg::BIT_SINGLE_WIRE_OE] : 1'b1;
				if (n.ctrl2[spicc_pkg::BIT_MODE_FAULT_ENABLE]
						&& n.ctrl1[spicc_pkg::BIT_SELECT_OUTPUT_ENABLE]) begin
					n.ss_e = 1'b1;
					n.ss_o = (n.state == spicc_pkg::ST_IDLE);
				end
			end else begin
				n.miso_o = out_bit(n.tx_sh, n.ctrl1[spicc_pkg::BIT_LOW_BIT_FIRST]);
				n.miso_e = !n.ss_s && (n.ctrl2[spicc_pkg::BIT_SINGLE_WIRE_SELECT] ?
					n.ctrl2[spicc_pkg::BIT_SINGLE_WIRE_OE] : 1'b1);
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rstn) begin
			q          <= '0;
			q.ctrl1    <= spicc_pkg::RST_CONTROL_PRIMARY;
			q.ctrl2    <= spicc_pkg::RST_CONTROL_SECONDARY;
			q.state    <= spicc_pkg::ST_IDLE;
			q.sclk_m   <= 1'b0;
			q.ss_m     <= 1'b1;
			q.ss_s     <= 1'b1;
			q.ss_o     <= 1'b1;
			q.irq      <= 1'b0;
		end else begin
			q <= n;
		end
	end

	// outputs straight from the state register
	assign rdata    = q.rdata;
	assign irq      = q.irq;
	assign sclk_out = q.sclk_o;
	assign sclk_oe  = q.sclk_e;
	assign mosi_out = q.mosi_o;
	assign mosi_oe  = q.mosi_e;
	assign miso_out = q.miso_o;
	assign miso_oe  = q.miso_e;
	assign ss_n_out = q.ss_o;
	assign ss_n_oe  = q.ss_e;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_RX_FAULT_IRQ: assert property (
		q.ctrl1[7] && (q.rf || q.mf) |-> irq)
		else $error("receive or fault event with enable set gave no interrupt");
	AST_TX_IRQ: assert property (
		q.ctrl1[5] && !q.tx_full |-> irq)
		else $error("transmit empty with enable set gave no interrupt");
	AST_IRQ_OFF: assert property (
		!q.ctrl1[7] && !q.ctrl1[5] |-> !irq)
		else $error("interrupt raised with both enables clear");
	AST_DISABLE: assert property (
		wr && addr == spicc_pkg::OFS_CONTROL_PRIMARY && !wdata[6]
		|=> q.state == spicc_pkg::ST_IDLE && !q.tx_full && !q.rf && q.edge_cnt == 5'h00)
		else $error("disable left engine or buffers active");
	AST_RELEASED: assert property (
		!q.ctrl1[6] |-> !sclk_oe && !mosi_oe && !miso_oe && !ss_n_oe)
		else $error("pin driven while disabled");
	AST_ROLE: assert property (
		q.ctrl1[6] |-> sclk_oe == q.ctrl1[4])
		else $error("clock pin direction does not follow role");
	AST_IDLE_LEVEL: assert property (
		q.ctrl1[6] && q.ctrl1[4] && q.edge_cnt == 5'h00 |-> sclk_out == q.ctrl1[3])
		else $error("serial clock not at idle level before first edge");
	AST_SELECT_PIN: assert property (
		q.ctrl1[6] |-> ss_n_oe == (q.ctrl1[4] && q.ctrl2[4] && q.ctrl1[1]))
		else $error("select pin drive wrong for role and enables");
	AST_SINGLE_WIRE: assert property (
		q.ctrl1[6] && q.ctrl1[4] && q.ctrl2[0] |-> mosi_oe == q.ctrl2[3] && !miso_oe)
		else $error("master shared data pin drive wrong");
	AST_WAIT_STOP: assert property (
		wait_mode && q.ctrl2[1] && q.state == spicc_pkg::ST_SHIFT |=> $stable(q.edge_cnt))
		else $error("engine moved while clocks stopped in wait");
	AST_SEC_ZERO: assert property (
		rd && addr == spicc_pkg::OFS_CONTROL_SECONDARY |=> rdata[7:5] == 3'h0 && rdata[2] == 1'b0)
		else $error("unimplemented secondary bits read nonzero");
	AST_READBACK: assert property (
		rd && addr == spicc_pkg::OFS_CONTROL_PRIMARY |=> rdata == $past(q.ctrl1))
		else $error("primary control read back wrong");
	AST_BYTE_LEN: assert property (
		q.state == spicc_pkg::ST_END |-> q.edge_cnt == spicc_pkg::EDGES_PER_BYTE)
		else $error("byte ended after wrong edge count");

	// role, select and landing checks
	AST_FAULT_SET: assert property (
		q.ctrl1[6] && q.ctrl1[4] && q.ctrl2[4] && !q.ctrl1[1] && !q.ss_s |=> q.mf && !q.ctrl1[4])
		else $error("select low on a fault-checking master raised no mode fault");
	AST_AUTO_SELECT: assert property (
		q.ctrl1[6] && q.ctrl1[4] && q.ctrl2[4] && q.ctrl1[1]
		|-> ss_n_out == (q.state == spicc_pkg::ST_IDLE))
		else $error("automatic select output does not follow the transfer");
	AST_SLAVE_PINS: assert property (
		q.ctrl1[6] && !q.ctrl1[4] |-> !mosi_oe && miso_oe == (!q.ss_s && (!q.ctrl2[0] || q.ctrl2[3])))
		else $error("slave data pin drive wrong");
	AST_DISABLED_FLAGS: assert property (
		!q.ctrl1[6] |-> !q.tx_full && !q.rf)
		else $error("flags not emptied while disabled");
	AST_RX_LAND: assert property (
		q.state == spicc_pkg::ST_END |=> q.rx_buf == $past(q.rx_sh) && (q.rf || !q.ctrl1[6]))
		else $error("received byte did not land with receive-full set");

	COV_MASTER_BYTE: cover property (q.state == spicc_pkg::ST_END && q.ctrl1[4]);
	COV_SLAVE_BYTE:  cover property (q.state == spicc_pkg::ST_END && !q.ctrl1[4]);
	COV_MODE_FAULT:  cover property ($rose(q.mf));
	COV_SINGLE_WIRE: cover property (q.state == spicc_pkg::ST_SHIFT && q.ctrl2[0]);
	COV_WAIT_FREEZE: cover property (wait_mode && q.ctrl2[1] && q.state == spicc_pkg::ST_SHIFT);

endmodule // spicc_ctrl

// >>> dv/spicc_partner.sv
// serial slave model that answers the master engine of the control block
`timescale 1ns/100ps
module spicc_partner (
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic       lsbf,
	input  wire logic       sel_n,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic      [7:0] rx_byte
);
	int   o_idx = 8;
	int   r_idx = 0;
	logic last  = 1'b0;
	logic b;

	// a new byte starts at each select; phase 1 launches on the first edge
	always @(negedge sel_n) begin
		o_idx = clock_phase ? -1 : 0;
		r_idx = 0;
	end

	// leading edge leaves the idle level; capture on leading for phase 0, trailing for phase 1
	always @(sclk) begin
		if (!sel_n && r_idx < 8) begin
			if ((sclk != clock_polarity) != clock_phase) begin
				rx_byte[lsbf ? r_idx : 7 - r_idx] = mosi;
				r_idx++;
			end else
				o_idx++;
		end
	end

	// released or out of range: show the inverse of the last bit, never a stale value
	always @(o_idx or sel_n or tx_byte or lsbf) begin
		if (!sel_n && o_idx >= 0 && o_idx < 8) begin
			b    = tx_byte[lsbf ? o_idx : 7 - o_idx];
			miso = b;
			last = b;
		end else
			miso = ~last;
	end
endmodule // spicc_partner

// >>> dv/spi_control_config_bench.sv
// self-checking bench for the serial control block
`timescale 1ns/100ps
module spi_control_config_bench;
	logic       clock = 0, rstn = 0, wr = 0, rd = 0, wait_mode = 0, ss_b = 1;
	logic       clock_polarity = 0, clock_phase = 0, lsbf = 0;
	logic       m_sclk = 0, m_mosi = 0;
	logic [2:0] addr  = 3'h0;
	logic [7:0] wdata = 8'h00, v, d, ptx = 8'h00, prx;
	logic [7:0] rdata;
	logic       irq, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe, p_miso;
	wire        sclk_w = sclk_oe ? sclk_out : m_sclk; // bench master clock, idles low
	wire        mosi_w = mosi_oe ? mosi_out : m_mosi; // bench master data
	wire        miso_w = miso_oe ? miso_out : p_miso;
	wire        ss_w   = ss_n_oe ? ss_n_out : ss_b;
	int         n_errors = 0, tests_run = 0;

	always #4 clock = ~clock;

	spicc_ctrl #(.HALF_CYCLES(5)) i_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .wait_mode(wait_mode), .irq(irq), .sclk_in(sclk_w), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
		.miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_w), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));

	spicc_partner i_partner (.sclk(sclk_w), .mosi(mosi_w), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsbf(lsbf),
		.sel_n(ss_w), .tx_byte(ptx), .miso(p_miso), .rx_byte(prx));

	// ************************************************************
	// bus tasks and comparisons
	// ************************************************************
	task automatic wreg(input logic [2:0] a, input logic [7:0] x);
		@(posedge clock) begin wr <= 1'b1; addr <= a; wdata <= x; end
		@(posedge clock) wr <= 1'b0;
	endtask

	task automatic rreg(input logic [2:0] a);
		@(posedge clock) begin rd <= 1'b1; addr <= a; end
		@(posedge clock) rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic sel();
		@(posedge clock) ss_b <= 1'b1;
		@(posedge clock) ss_b <= 1'b0;
	endtask

	task automatic poll();
		int k;
		v = 8'h00;
		for (k = 0; k < 60 && v[7] !== 1'b1; k++)
			rreg(3'h3);
		chk(v & 8'h80, 8'h80);
	endtask

	// bench as master of a slave-role byte: polarity 0, phase 0, msb first, 80 ns clock
	task automatic mxfer(input logic [7:0] mo);
		@(posedge clock) m_mosi <= mo[7];
		for (int j = 7; j >= 0; j--) begin
			repeat (5) @(posedge clock);
			m_sclk <= 1'b1;
			d[j]   = miso_w;
			repeat (5) @(posedge clock);
			m_sclk <= 1'b0;
			if (j > 0)
				m_mosi <= mo[j - 1];
		end
		repeat (6) @(posedge clock);
	endtask

	task automatic give_verdict();
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		rreg(3'h0); chk(v, 8'h04);
		rreg(3'h1); chk(v, 8'h00);
		rreg(3'h2); chk(v, 8'h00);
		wreg(3'h1, 8'hFF); rreg(3'h1); chk(v, 8'h1B);
		wreg(3'h0, 8'h2B); rreg(3'h0); chk(v, 8'h2B);
		rreg(3'h3); chk(v, 8'h20);
		chk({7'h0, irq}, 8'h01);
		chk({sclk_oe, mosi_oe, miso_oe, ss_n_oe, 4'h0}, 8'h00);
		wreg(3'h0, 8'h0B); repeat (3) @(posedge clock);
		chk({7'h0, irq}, 8'h00);
		wreg(3'h1, 8'h00);
		// every polarity, phase and order, phase set while disabled
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) {clock_polarity, clock_phase, lsbf} <= 3'(i);
			wreg(3'h0, 8'h90 | {4'h0, 1'(i >> 2), 1'(i >> 1), 1'b0, 1'(i)});
			wreg(3'h0, 8'hD0 | {4'h0, 1'(i >> 2), 1'(i >> 1), 1'b0, 1'(i)});
			repeat (4) @(posedge clock);
			chk({6'h0, sclk_oe, sclk_out}, {6'h0, 1'b1, clock_polarity});
			ptx <= 8'h5A + 8'(i * 17);
			d = 8'hC3 ^ 8'(i);
			sel();
			wreg(3'h5, d);
			poll();
			chk({7'h0, irq}, 8'h01);
			rreg(3'h5); chk(v, ptx);
			chk(prx, d);
			repeat (3) @(posedge clock);
			chk({7'h0, irq}, 8'h00);
			wreg(3'h0, 8'h90 | {4'h0, 1'(i >> 2), 1'(i >> 1), 1'b0, 1'(i)});
		end
		// disabling mid-byte aborts and empties
		@(posedge clock) {clock_polarity, clock_phase, lsbf} <= 3'h0;
		wreg(3'h0, 8'h50); sel(); wreg(3'h5, 8'h96);
		repeat (30) @(posedge clock);
		wreg(3'h0, 8'h10);
		rreg(3'h3); chk(v, 8'h20);
		chk({sclk_oe, mosi_oe, miso_oe, ss_n_oe, 4'h0}, 8'h00);
		wreg(3'h0, 8'h50); repeat (200) @(posedge clock);
		rreg(3'h3); chk(v, 8'h20);
		chk({7'h0, ss_n_oe}, 8'h00);
		// wait mode stops the engine until released
		wreg(3'h1, 8'h02); sel(); wreg(3'h5, 8'h11);
		repeat (20) @(posedge clock);
		wait_mode <= 1'b1;
		repeat (100) @(posedge clock);
		rreg(3'h3); chk(v & 8'h80, 8'h00);
		@(posedge clock) wait_mode <= 1'b0;
		poll();
		rreg(3'h5);
		// automatic select output while the byte runs
		@(posedge clock) ss_b <= 1'b1;
		wreg(3'h1, 8'h10); wreg(3'h0, 8'h52); wreg(3'h5, 8'h3C);
		repeat (8) @(posedge clock);
		chk({6'h0, ss_n_oe, ss_n_out}, 8'h02);
		poll(); rreg(3'h5);
		// select as fault input
		@(posedge clock) ss_b <= 1'b1;
		wreg(3'h0, 8'hD0); repeat (4) @(posedge clock);
		chk({7'h0, ss_n_oe}, 8'h00);
		@(posedge clock) ss_b <= 1'b0;
		repeat (8) @(posedge clock);
		rreg(3'h3); chk(v, 8'h30);
		rreg(3'h0); chk(v, 8'hC0);
		chk({7'h0, irq}, 8'h01);
		// slave role ignores fault and output enables
		@(posedge clock) ss_b <= 1'b1;
		wreg(3'h0, 8'h42); rreg(3'h3); wreg(3'h0, 8'h42); // clear the fault
		chk({sclk_oe, ss_n_oe, 6'h0}, 8'h00);
		wreg(3'h5, 8'hA6);
		@(posedge clock) ss_b <= 1'b0;
		repeat (6) @(posedge clock);
		chk({6'h0, miso_oe, mosi_oe}, 8'h02);
		rreg(3'h3); chk(v & 8'h10, 8'h00);
		mxfer(8'h3D);
		chk(d, 8'hA6);
		rreg(3'h5);
		chk(v, 8'h3D);
		// single wire: master shares mosi, slave shares miso
		@(posedge clock) ss_b <= 1'b1;
		wreg(3'h1, 8'h09); wreg(3'h0, 8'h50); repeat (3) @(posedge clock);
		chk({6'h0, mosi_oe, miso_oe}, 8'h02);
		wreg(3'h1, 8'h01); repeat (3) @(posedge clock);
		chk({6'h0, mosi_oe, miso_oe}, 8'h00);
		wreg(3'h1, 8'h09); wreg(3'h0, 8'h40); repeat (3) @(posedge clock);
		chk({6'h0, mosi_oe, miso_oe}, 8'h00);
		@(posedge clock) ss_b <= 1'b0;
		repeat (6) @(posedge clock);
		chk({6'h0, mosi_oe, miso_oe}, 8'h01);
		give_verdict();
	end
endmodule // spi_control_config_bench
